//--- rtl/sct_pkg.sv
// shared constants and types for the scl timing block
package sct_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam logic [15:0] SCL_LOW_ADDR    = 16'h0341;
  localparam logic [15:0] SCL_HIGH_ADDR   = 16'h0342;
  localparam logic [15:0] SCL_LOW_RESET   = 16'h0144;
  localparam logic [15:0] SCL_HIGH_RESET  = 16'h0114;
  localparam logic [15:0] UNMAPPED_READ   = 16'h0000;
  localparam int          CORE_CLK_HZ     = 60000000;
  localparam int          CORE_PERIOD_PS  = 1000000000 / (CORE_CLK_HZ / 1000);
  localparam logic [15:0] MIN_COUNT       = 16'h0001;
  typedef enum logic [1:0] {
    SCT_IDLE,
    SCT_LOW,
    SCT_WAIT_HIGH,
    SCT_HIGH
  } sct_state_e;
endpackage : sct_pkg

//--- rtl/sct_sync3.sv
// three-stage synchroniser, output follows once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module sct_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;
  logic q_nxt;

  always_comb begin
    q_nxt = (s2_r == s3_r) ? s3_r : q_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      q_r  <= RESET_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : sct_sync3
`default_nettype wire

//--- rtl/sct_scl_timing.sv
// scl low/high period generator with its hid register pair
// Function
// - as master, hold scl low for the programmed 16-bit low-period count
// - low and high periods count core clock cycles, about 16.7 ns each
// - slave may stretch low; high phase starts only once scl seen high
// - registers are 16 bits, reset nonzero; low-period register resets 0x0144
// - hold scl high for high-period register count, reset 0x0114; may be cut
`timescale 1ns/1ns
`default_nettype none
module sct_scl_timing
  import sct_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic                 sys_clk,
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire logic                 hid_wr_en,
  input  wire logic                 hid_rd_en,
  input  wire logic [sct_pkg::ADDR_W-1:0] hid_addr,
  input  wire logic [sct_pkg::DATA_W-1:0] hid_wr_data,
  output logic      [sct_pkg::DATA_W-1:0] hid_rd_data,
  output logic                      hid_rd_valid,
  input  wire logic                 master_en,
  input  wire logic                 scl_in,
  output logic                      scl_out,
  output logic                      scl_oe_n,
  output logic                      scl_stretching
);
  import sct_pkg::*;

  // reset release, one copy per domain
  logic sys_rst1_r;
  logic sys_rst_n;
  logic core_rst1_r;
  logic core_rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_rst1_r <= 1'b0;
      sys_rst_n  <= 1'b0;
    end else begin
      sys_rst1_r <= 1'b1;
      sys_rst_n  <= sys_rst1_r;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_rst1_r <= 1'b0;
      core_rst_n  <= 1'b0;
    end else begin
      core_rst1_r <= 1'b1;
      core_rst_n  <= core_rst1_r;
    end
  end

  // register side, sys_clk
  logic [DATA_W-1:0] low_r;
  logic [DATA_W-1:0] low_nxt;
  logic [DATA_W-1:0] high_r;
  logic [DATA_W-1:0] high_nxt;
  logic [DATA_W-1:0] xlow_r;
  logic [DATA_W-1:0] xlow_nxt;
  logic [DATA_W-1:0] xhigh_r;
  logic [DATA_W-1:0] xhigh_nxt;
  logic              req_r;
  logic              req_nxt;
  logic              pend_r;
  logic              pend_nxt;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic              rd_valid_r;
  logic              rd_valid_nxt;
  logic              ack_s;
  logic              wr_low;
  logic              wr_high;

  always_comb begin
    wr_low       = hid_wr_en && (hid_addr == SCL_LOW_ADDR);
    wr_high      = hid_wr_en && (hid_addr == SCL_HIGH_ADDR);
    low_nxt      = wr_low ? hid_wr_data : low_r;
    high_nxt     = wr_high ? hid_wr_data : high_r;
    xlow_nxt     = xlow_r;
    xhigh_nxt    = xhigh_r;
    req_nxt      = req_r;
    pend_nxt     = pend_r || wr_low || wr_high;
    // one word pair in flight; later writes wait and are sent together
    if (pend_r && (req_r == ack_s)) begin
      xlow_nxt  = low_r;
      xhigh_nxt = high_r;
      req_nxt   = ~req_r;
      pend_nxt  = wr_low || wr_high;
    end
    rd_valid_nxt = hid_rd_en;
    rd_data_nxt  = rd_data_r;
    if (hid_rd_en) begin
      if (hid_addr == SCL_LOW_ADDR) begin
        rd_data_nxt = low_r;
      end else if (hid_addr == SCL_HIGH_ADDR) begin
        rd_data_nxt = high_r;
      end else begin
        rd_data_nxt = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      low_r      <= SCL_LOW_RESET;
      high_r     <= SCL_HIGH_RESET;
      xlow_r     <= SCL_LOW_RESET;
      xhigh_r    <= SCL_HIGH_RESET;
      req_r      <= 1'b0;
      pend_r     <= 1'b0;
      rd_data_r  <= UNMAPPED_READ;
      rd_valid_r <= 1'b0;
    end else begin
      low_r      <= low_nxt;
      high_r     <= high_nxt;
      xlow_r     <= xlow_nxt;
      xhigh_r    <= xhigh_nxt;
      req_r      <= req_nxt;
      pend_r     <= pend_nxt;
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign hid_rd_data  = rd_data_r;
  assign hid_rd_valid = rd_valid_r;

  // crossings
  logic req_s;
  logic ack_r;
  logic run_s;
  logic scl_s;

  sct_sync3 #(.RESET_VAL(1'b0)) u_req_sync (
    .clk   (core_clk),
    .rst_n (core_rst_n),
    .d     (req_r),
    .q     (req_s)
  );

  sct_sync3 #(.RESET_VAL(1'b0)) u_ack_sync (
    .clk   (sys_clk),
    .rst_n (sys_rst_n),
    .d     (ack_r),
    .q     (ack_s)
  );

  sct_sync3 #(.RESET_VAL(1'b0)) u_run_sync (
    .clk   (core_clk),
    .rst_n (core_rst_n),
    .d     (master_en),
    .q     (run_s)
  );

  // bus released by default, pulled up
  sct_sync3 #(.RESET_VAL(1'b1)) u_scl_sync (
    .clk   (core_clk),
    .rst_n (core_rst_n),
    .d     (scl_in),
    .q     (scl_s)
  );

  // scl engine, core_clk; one count is one core clock period
  logic [CNT_W-1:0] lowc_r;
  logic [CNT_W-1:0] lowc_nxt;
  logic [CNT_W-1:0] highc_r;
  logic [CNT_W-1:0] highc_nxt;
  logic             ack_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  sct_state_e       state_r;
  sct_state_e       state_nxt;
  logic             oe_n_r;
  logic             oe_n_nxt;
  logic [CNT_W-1:0] low_eff;
  logic [CNT_W-1:0] high_eff;

  always_comb begin
    lowc_nxt  = lowc_r;
    highc_nxt = highc_r;
    ack_nxt   = ack_r;
    // words stay still while the toggle is unanswered
    if (req_s != ack_r) begin
      lowc_nxt  = xlow_r[CNT_W-1:0];
      highc_nxt = xhigh_r[CNT_W-1:0];
      ack_nxt   = req_s;
    end
    // zero is loaded as one; either count ends a phase after one cycle
    low_eff   = (lowc_r == '0) ? MIN_COUNT[CNT_W-1:0] : lowc_r;
    high_eff  = (highc_r == '0) ? MIN_COUNT[CNT_W-1:0] : highc_r;
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      SCT_IDLE: begin
        if (run_s) begin
          state_nxt = SCT_LOW;
          cnt_nxt   = low_eff;
        end
      end
      SCT_LOW: begin
        if (cnt_r <= MIN_COUNT[CNT_W-1:0]) begin
          state_nxt = SCT_WAIT_HIGH;
        end else begin
          cnt_nxt = cnt_r - MIN_COUNT[CNT_W-1:0];
        end
      end
      SCT_WAIT_HIGH: begin
        if (scl_s) begin
          state_nxt = SCT_HIGH;
          cnt_nxt   = high_eff;
        end
      end
      SCT_HIGH: begin
        if (!scl_s) begin
          state_nxt = SCT_LOW;
          cnt_nxt   = low_eff;
        end else if (cnt_r <= MIN_COUNT[CNT_W-1:0]) begin
          state_nxt = run_s ? SCT_LOW : SCT_IDLE;
          cnt_nxt   = low_eff;
        end else begin
          cnt_nxt = cnt_r - MIN_COUNT[CNT_W-1:0];
        end
      end
      default: begin
        state_nxt = SCT_IDLE;
      end
    endcase
    oe_n_nxt = (state_nxt != SCT_LOW);
  end

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      lowc_r  <= SCL_LOW_RESET[CNT_W-1:0];
      highc_r <= SCL_HIGH_RESET[CNT_W-1:0];
      ack_r   <= 1'b0;
      cnt_r   <= '0;
      state_r <= SCT_IDLE;
      oe_n_r  <= 1'b1;
    end else begin
      lowc_r  <= lowc_nxt;
      highc_r <= highc_nxt;
      ack_r   <= ack_nxt;
      cnt_r   <= cnt_nxt;
      state_r <= state_nxt;
      oe_n_r  <= oe_n_nxt;
    end
  end

  // open drain: only ever pulls low
  assign scl_out        = 1'b0;
  assign scl_oe_n       = oe_n_r;
  assign scl_stretching = (state_r == SCT_WAIT_HIGH);
endmodule : sct_scl_timing
`default_nettype wire

//--- test/sct_asserts.sv
// checker for the scl timing block ports
`timescale 1ns/1ns
`default_nettype none
module sct_asserts (
  input wire logic        sys_clk,
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        hid_rd_en,
  input wire logic [15:0] hid_addr,
  input wire logic [15:0] hid_rd_data,
  input wire logic        hid_rd_valid,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe_n,
  input wire logic        scl_stretching
);
  chk_rd_answer: assert property (@(posedge sys_clk) disable iff (!reset_n)
    hid_rd_en |=> hid_rd_valid) else $error("read lost");
  chk_rd_cause: assert property (@(posedge sys_clk) disable iff (!reset_n)
    hid_rd_valid |-> $past(hid_rd_en)) else $error("stray valid");
  chk_rd_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !hid_rd_valid |-> $stable(hid_rd_data)) else $error("data moved");
  chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    hid_rd_en && hid_addr != 16'h0341 && hid_addr != 16'h0342 |=> hid_rd_data == 16'h0000) else $error("bad read");
  chk_open_drain: assert property (@(posedge core_clk) disable iff (!reset_n)
    scl_out == 1'b0) else $error("scl driven high");
  chk_stretch_free: assert property (@(posedge core_clk) disable iff (!reset_n)
    scl_stretching |-> scl_oe_n) else $error("pulls while waiting");
  chk_stretch_end: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(scl_stretching) |-> $past(scl_in, 4) && $past(scl_in, 5) && scl_oe_n) else $error("high without scl");
  chk_release_wait: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(scl_oe_n) |-> scl_stretching) else $error("no wait after low");
  cover property (@(posedge sys_clk) hid_rd_valid);
  cover property (@(posedge core_clk) $fell(scl_stretching));
  cover property (@(posedge core_clk) scl_oe_n && !scl_stretching && !scl_in);
endmodule : sct_asserts
`default_nettype wire

//--- test/sct_bus_model.sv
// far side of scl: pull-up, stretching slave, second master
`timescale 1ns/1ns
`default_nettype none
module sct_bus_model (
  input  wire logic       core_clk,
  input  wire logic       scl_oe_n,
  input  wire logic [7:0] hold,
  input  wire logic       other_pull,
  output logic            scl_line
);
  logic [7:0] held = 8'hFF;
  always @(posedge core_clk) begin
    if (!scl_oe_n) held <= 8'h00;
    else if (held != 8'hFF) held <= held + 8'h01;
  end
  // wired-and with pull-up; slave holds low hold cycles after release
  assign scl_line = scl_oe_n && !other_pull && (held >= hold);
endmodule : sct_bus_model
`default_nettype wire

//--- test/testbench.sv
// bench for the scl timing block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sct_pkg::*;
  logic        sys_clk, core_clk, reset_n, wr, rd, men, pull, rv, scl, sout, oe_n, str;
  logic [15:0] addr, wdata, rdata;
  logic [7:0]  hold;
  int          num_errors, num_checks, lo, hi, g, st;
  sct_scl_timing u_dut (.sys_clk(sys_clk), .core_clk(core_clk), .reset_n(reset_n), .hid_wr_en(wr), .hid_rd_en(rd),
    .hid_addr(addr), .hid_wr_data(wdata), .hid_rd_data(rdata), .hid_rd_valid(rv), .master_en(men), .scl_in(scl),
    .scl_out(sout), .scl_oe_n(oe_n), .scl_stretching(str));
  sct_bus_model u_bus (.core_clk(core_clk), .scl_oe_n(oe_n), .hold(hold), .other_pull(pull), .scl_line(scl));
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    core_clk = 0;
    #5;
    forever #32 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] a, d);
    @(posedge sys_clk);
    #1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge sys_clk);
    #1;
    wr = 0;
    rd = 0;
    if (!w) chk(rv === 1'b1 ? rdata : 16'hDEAD, d);
  endtask : acc
  // bounded wait step; runaway counts end the run
  task automatic tick(inout int n);
    @(posedge core_clk);
    #1;
    n++;
    if (n > 5000) begin
      num_errors++;
      give_verdict();
    end
  endtask : tick
  task automatic meas();
    g = 0;
    while (oe_n !== 1'b1) tick(g);
    while (oe_n !== 1'b0) tick(g);
    lo = 0;
    while (oe_n === 1'b0) tick(lo);
    st = 0;
    while (str !== 1'b0) tick(st);
    hi = 0;
    while (oe_n === 1'b1) tick(hi);
  endtask : meas
  initial begin
    reset_n = 0;
    wr = 0;
    rd = 0;
    men = 0;
    pull = 0;
    hold = 8'h00;
    addr = 16'h0000;
    wdata = 16'h0000;
    repeat (10) @(posedge sys_clk);
    #1;
    reset_n = 1;
    repeat (3) @(posedge sys_clk);
    acc(1'b0, SCL_LOW_ADDR, SCL_LOW_RESET);
    acc(1'b0, SCL_HIGH_ADDR, SCL_HIGH_RESET);
    acc(1'b1, 16'h0343, 16'hBEEF);
    acc(1'b0, 16'h0343, 16'h0000);
    // 400 kbps timing, kept at the software minimums
    acc(1'b1, SCL_LOW_ADDR, 16'h004E);
    acc(1'b1, SCL_HIGH_ADDR, 16'h0048);
    acc(1'b0, SCL_LOW_ADDR, 16'h004E);
    acc(1'b0, SCL_HIGH_ADDR, 16'h0048);
    men = 1;
    meas();
    meas();
    chk(lo[15:0], 16'h004E);
    chk(hi[15:0], 16'h0048);
    hold = 8'h0A;
    meas();
    chk(lo[15:0], 16'h004E);
    chk(hi[15:0], 16'h0048);
    chk({15'h0000, st > 10}, 16'h0001);
    hold = 8'h00;
    g = 0;
    while (!(oe_n === 1'b1 && str === 1'b0)) tick(g);
    hi = 0;
    repeat (3) tick(hi);
    pull = 1;
    while (oe_n === 1'b1) tick(hi);
    pull = 0;
    chk({15'h0000, hi < 10}, 16'h0001);
    lo = 0;
    while (oe_n === 1'b0) tick(lo);
    chk(lo[15:0], 16'h004E);
    // live change to 100 kbps timing, taken at a later phase load
    acc(1'b1, SCL_LOW_ADDR, 16'h00FC);
    acc(1'b1, SCL_HIGH_ADDR, 16'h015C);
    meas();
    meas();
    chk(lo[15:0], 16'h00FC);
    chk(hi[15:0], 16'h015C);
    men = 0;
    // long enough to finish the running low and high phases
    repeat (700) tick(g);
    chk({15'h0000, oe_n}, 16'h0001);
    give_verdict();
  end
endmodule : testbench
bind sct_scl_timing sct_asserts u_chk (.sys_clk(sys_clk), .core_clk(core_clk), .reset_n(reset_n),
  .hid_rd_en(hid_rd_en), .hid_addr(hid_addr), .hid_rd_data(hid_rd_data), .hid_rd_valid(hid_rd_valid),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .scl_stretching(scl_stretching));
`default_nettype wire
